/* rtl/aesenc_map.svh */
`ifndef AESENC_MAP_SVH
`define AESENC_MAP_SVH

// Cycle counts, counted on busy cycles
`define AESENC_KEY_CYCLES 4'hE
`define AESENC_ENC_CYCLES 4'hE
`define AESENC_LAST_KEY_STEP 4'hD
`define AESENC_CNT_FIRST 4'h1

// Reset values
`define AESENC_CNT_RST 4'h0
`define AESENC_BLOCK_RST 128'h0

// Key word halves
`define AESENC_KEY_HI 255:128
`define AESENC_KEY_LO 127:0

`endif

/* rtl/aesenc_pkg.sv */
package aesenc_pkg;

  typedef logic [127:0] aesenc_block_t;
  typedef logic [255:0] aesenc_key_t;
  typedef logic [31:0]  aesenc_word_t;
  typedef logic [3:0]   aesenc_cnt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_KEY,
    ST_ENC
  } aesenc_state_t;

  localparam logic [2047:0] SBOX = {
    128'h637C777BF26B6FC53001672BFED7AB76, 128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
    128'hB7FD9326363FF7CC34A5E5F171D83115, 128'h04C723C31896059A071280E2EB27B275,
    128'h09832C1A1B6E5AA0523BD6B329E32F84, 128'h53D100ED20FCB15B6ACBBE394A4C58CF,
    128'hD0EFAAFB434D338545F9027F503C9FA8, 128'h51A3408F929D38F5BCB6DA2110FFF3D2,
    128'hCD0C13EC5F974417C4A77E3D645D1973, 128'h60814FDC222A908846EEB814DE5E0BDB,
    128'hE0323A0A4906245CC2D3AC629195E479, 128'hE7C8376D8DD54EA96C56F4EA657AAE08,
    128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A, 128'h703EB5664803F60E613557B986C11D9E,
    128'hE1F8981169D98E949B1E87E9CE5528DF, 128'h8CA1890DBFE6426841992D0FB054BB16
  };

  function automatic logic [7:0] sbox(input logic [7:0] x);
    sbox = SBOX[2047 - 8 * x -: 8];
  endfunction : sbox

  function automatic logic [7:0] xtime(input logic [7:0] x);
    xtime = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
  endfunction : xtime

  function automatic aesenc_word_t subword(input aesenc_word_t w);
    subword = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction : subword

  // Round constant for step index 1..7
  function automatic logic [7:0] rcon(input logic [2:0] i);
    rcon = 8'h01 << (i - 3'h1);
  endfunction : rcon

endpackage : aesenc_pkg

/* rtl/aesenc_core_if.sv */
`timescale 1ns/1ns
interface aesenc_core_if;
  aesenc_pkg::aesenc_block_t rnd_state;
  aesenc_pkg::aesenc_block_t rnd_key;
  logic                      rnd_last;
  aesenc_pkg::aesenc_block_t rnd_out;
  aesenc_pkg::aesenc_block_t kx_prev2;
  aesenc_pkg::aesenc_block_t kx_prev1;
  aesenc_pkg::aesenc_cnt_t   kx_index;
  aesenc_pkg::aesenc_block_t kx_out;

  modport rnd  (input rnd_state, rnd_key, rnd_last, output rnd_out);
  modport kexp (input kx_prev2, kx_prev1, kx_index, output kx_out);
  modport ctrl (output rnd_state, rnd_key, rnd_last, kx_prev2, kx_prev1, kx_index,
                input rnd_out, kx_out);
endinterface : aesenc_core_if

/* rtl/aesenc_round.sv */
`timescale 1ns/1ns
module aesenc_round (
  // Round datapath
  aesenc_core_if.rnd core
);

  logic [7:0] sb [16];
  logic [7:0] sr [16];
  logic [7:0] mc [16];
  aesenc_pkg::aesenc_block_t mixed;

  // Bytes are column-major, byte 0 in the top bits
  always_comb begin
    mixed = '0;
    for (int i = 0; i < 16; i++) begin
      sb[i] = aesenc_pkg::sbox(core.rnd_state[127 - 8 * i -: 8]);
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        sr[4 * c + r] = sb[4 * ((c + r) % 4) + r];
      end
    end
    for (int c = 0; c < 4; c++) begin
      mc[4*c]   = aesenc_pkg::xtime(sr[4*c] ^ sr[4*c+1]) ^ sr[4*c+1] ^ sr[4*c+2] ^ sr[4*c+3];
      mc[4*c+1] = aesenc_pkg::xtime(sr[4*c+1] ^ sr[4*c+2]) ^ sr[4*c] ^ sr[4*c+2] ^ sr[4*c+3];
      mc[4*c+2] = aesenc_pkg::xtime(sr[4*c+2] ^ sr[4*c+3]) ^ sr[4*c] ^ sr[4*c+1] ^ sr[4*c+3];
      mc[4*c+3] = aesenc_pkg::xtime(sr[4*c+3] ^ sr[4*c]) ^ sr[4*c] ^ sr[4*c+1] ^ sr[4*c+2];
    end
    for (int i = 0; i < 16; i++) begin
      // Final round skips the column mix
      mixed[127 - 8 * i -: 8] = core.rnd_last ? sr[i] : mc[i];
    end
    core.rnd_out = mixed ^ core.rnd_key;
  end

endmodule : aesenc_round

/* rtl/aesenc_keyexp.sv */
`timescale 1ns/1ns
module aesenc_keyexp (
  // One round key per step
  aesenc_core_if.kexp core
);

  aesenc_pkg::aesenc_word_t f;
  aesenc_pkg::aesenc_word_t w0;
  aesenc_pkg::aesenc_word_t w1;
  aesenc_pkg::aesenc_word_t w2;
  aesenc_pkg::aesenc_word_t w3;
  aesenc_pkg::aesenc_word_t last;

  always_comb begin
    last = core.kx_prev1[31:0];
    // Even round keys rotate and add the round constant, odd ones only substitute
    if (!core.kx_index[0]) begin
      f = aesenc_pkg::subword({last[23:0], last[31:24]})
          ^ {aesenc_pkg::rcon(core.kx_index[3:1]), 24'h000000};
    end else begin
      f = aesenc_pkg::subword(last);
    end
    w0 = core.kx_prev2[127:96] ^ f;
    w1 = core.kx_prev2[95:64] ^ w0;
    w2 = core.kx_prev2[63:32] ^ w1;
    w3 = core.kx_prev2[31:0] ^ w2;
    core.kx_out = {w0, w1, w2, w3};
  end

endmodule : aesenc_keyexp

/* rtl/aesenc_top.sv */
`timescale 1ns/1ns
`include "aesenc_map.svh"
// Functional notes
// - ECB: each block alone, current key
// - Take 256-bit key, AES-256 schedule
// - 128-bit plaintext in, 128-bit ciphertext out
// - Fixed 15-cycle encryption per block
// - Idle key valid captures key, starts
// - Key setting ends after 14 cycles
// - Key busy high through last cycle
// - Key done only on last cycle
// - Key busy ignores both valid inputs
// - Key stays until next key load or reset
// - Idle plain valid without key valid captures block, starts
// - Encrypt busy next cycle, 14 cycles
// - Encrypt busy ignores both valid inputs
// - Encrypt done only on last cycle
// - Ciphertext out with its valid strobe
// - Active-low reset returns idle, outputs low
module aesenc_top (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Key setting
  input  wire logic         key_load_valid,
  input  wire logic [255:0] key_word,
  output logic              key_load_busy,
  output logic              key_load_done,
  // Encryption
  input  wire logic         plain_valid,
  input  wire logic [127:0] plain_block,
  output logic              encrypt_busy,
  output logic              encrypt_done,
  output logic              cipher_valid,
  output logic [127:0]      cipher_block
);

  ////////////////////////////////////////////////////////////////////////
  // State

  aesenc_pkg::aesenc_state_t state_q;
  aesenc_pkg::aesenc_state_t state_d;
  aesenc_pkg::aesenc_cnt_t   cnt_q;
  aesenc_pkg::aesenc_cnt_t   cnt_d;
  aesenc_pkg::aesenc_block_t blk_q;
  aesenc_pkg::aesenc_block_t blk_d;
  aesenc_pkg::aesenc_block_t cipher_q;
  aesenc_pkg::aesenc_block_t cipher_d;
  aesenc_pkg::aesenc_block_t rk_q [15];
  aesenc_pkg::aesenc_block_t rk_d [15];
  logic                      key_busy_q;
  logic                      key_busy_d;
  logic                      key_done_q;
  logic                      key_done_d;
  logic                      enc_busy_q;
  logic                      enc_busy_d;
  logic                      enc_done_q;
  logic                      enc_done_d;
  logic                      valid_q;
  logic                      valid_d;
  logic                      idle;
  logic                      key_start;
  logic                      enc_start;

  ////////////////////////////////////////////////////////////////////////
  // Datapath

  aesenc_core_if core ();

  aesenc_round u_round (
    .core (core.rnd)
  );

  aesenc_keyexp u_keyexp (
    .core (core.kexp)
  );

  // Round keys are never read at index 0 by the round unit
  assign core.rnd_state = blk_q;
  assign core.rnd_key   = rk_q[cnt_q];
  assign core.rnd_last  = (cnt_q == `AESENC_ENC_CYCLES);
  assign core.kx_prev2  = (cnt_q == `AESENC_CNT_RST) ? rk_q[0] : rk_q[cnt_q - 4'h1];
  assign core.kx_prev1  = rk_q[cnt_q];
  assign core.kx_index  = 4'(cnt_q + 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // Control

  // Busy gates both strobes, so requests during an operation are dropped
  assign idle      = (state_q == aesenc_pkg::ST_IDLE);
  assign key_start = idle && key_load_valid;
  assign enc_start = idle && plain_valid && !key_load_valid;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    blk_d      = blk_q;
    cipher_d   = cipher_q;
    rk_d       = rk_q;
    key_busy_d = key_busy_q;
    key_done_d = 1'b0;
    enc_busy_d = enc_busy_q;
    enc_done_d = 1'b0;
    valid_d    = 1'b0;
    case (state_q)
      aesenc_pkg::ST_IDLE: begin
        if (key_start) begin
          // Key captured whole; first two round keys are the key itself
          state_d    = aesenc_pkg::ST_KEY;
          cnt_d      = `AESENC_CNT_FIRST;
          rk_d[0]    = key_word[`AESENC_KEY_HI];
          rk_d[1]    = key_word[`AESENC_KEY_LO];
          key_busy_d = 1'b1;
        end else if (enc_start) begin
          state_d    = aesenc_pkg::ST_ENC;
          cnt_d      = `AESENC_CNT_FIRST;
          blk_d      = plain_block ^ rk_q[0];
          enc_busy_d = 1'b1;
        end
      end
      aesenc_pkg::ST_KEY: begin
        if (cnt_q <= `AESENC_LAST_KEY_STEP) begin
          rk_d[cnt_q + 4'h1] = core.kx_out;
        end
        if (cnt_q == `AESENC_KEY_CYCLES) begin
          state_d    = aesenc_pkg::ST_IDLE;
          cnt_d      = `AESENC_CNT_RST;
          key_busy_d = 1'b0;
        end else begin
          cnt_d      = 4'(cnt_q + 4'h1);
          key_done_d = (cnt_d == `AESENC_KEY_CYCLES);
        end
      end
      aesenc_pkg::ST_ENC: begin
        if (cnt_q == `AESENC_ENC_CYCLES) begin
          // Ciphertext register holds until the next block lands
          state_d    = aesenc_pkg::ST_IDLE;
          cnt_d      = `AESENC_CNT_RST;
          enc_busy_d = 1'b0;
          cipher_d   = core.rnd_out;
          valid_d    = 1'b1;
        end else begin
          blk_d      = core.rnd_out;
          cnt_d      = 4'(cnt_q + 4'h1);
          enc_done_d = (cnt_d == `AESENC_ENC_CYCLES);
        end
      end
      default: begin
        state_d    = aesenc_pkg::ST_IDLE;
        cnt_d      = `AESENC_CNT_RST;
        key_busy_d = 1'b0;
        enc_busy_d = 1'b0;
      end
    endcase
  end

  // Round keys only change on reset, on a key start and during key setting, so they persist across blocks
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q    <= aesenc_pkg::ST_IDLE;
      cnt_q      <= `AESENC_CNT_RST;
      blk_q      <= `AESENC_BLOCK_RST;
      cipher_q   <= `AESENC_BLOCK_RST;
      key_busy_q <= 1'b0;
      key_done_q <= 1'b0;
      enc_busy_q <= 1'b0;
      enc_done_q <= 1'b0;
      valid_q    <= 1'b0;
      for (int i = 0; i < 15; i++) begin
        rk_q[i] <= `AESENC_BLOCK_RST;
      end
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      blk_q      <= blk_d;
      cipher_q   <= cipher_d;
      key_busy_q <= key_busy_d;
      key_done_q <= key_done_d;
      enc_busy_q <= enc_busy_d;
      enc_done_q <= enc_done_d;
      valid_q    <= valid_d;
      rk_q       <= rk_d;
    end
  end

  assign key_load_busy = key_busy_q;
  assign key_load_done = key_done_q;
  assign encrypt_busy  = enc_busy_q;
  assign encrypt_done  = enc_done_q;
  assign cipher_valid  = valid_q;
  assign cipher_block  = cipher_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!reset_n);

  sequence s_key_req;
    !key_load_busy && !encrypt_busy && key_load_valid;
  endsequence

  sequence s_enc_req;
    !key_load_busy && !encrypt_busy && plain_valid && !key_load_valid;
  endsequence

  sequence s_busy14_key;
    key_load_busy[*7] ##1 key_load_busy[*7];
  endsequence

  sequence s_busy14_enc;
    encrypt_busy[*7] ##1 encrypt_busy[*7];
  endsequence

  // Last busy cycle carries done, the next one carries the result
  sequence s_enc_finish;
    (encrypt_busy && encrypt_done) ##1 (cipher_valid && !encrypt_busy);
  endsequence

  // Key setting leaves nothing raised behind it
  sequence s_key_finish;
    (key_load_busy && key_load_done) ##1 (!key_load_busy && !key_load_done);
  endsequence

  a_key_busy_len: assert property (s_key_req |=> s_busy14_key ##1 !key_load_busy)
    else $error("key busy not 14 cycles");

  a_key_done_pos: assert property (
    s_key_req |=> !key_load_done[*7] ##1 !key_load_done[*6] ##1 key_load_done)
    else $error("key done not on last cycle");

  a_key_done_end: assert property (key_load_done |-> key_load_busy ##1 !key_load_busy)
    else $error("key done outside busy end");

  a_enc_latency: assert property (
    s_enc_req |=> s_busy14_enc ##1 (!encrypt_busy && cipher_valid))
    else $error("encryption not 15 cycles");

  a_enc_done_pos: assert property (encrypt_done |-> encrypt_busy ##1 cipher_valid)
    else $error("done not followed by valid");

  a_busy_excl: assert property (key_load_busy |-> !encrypt_busy)
    else $error("both busy together");

  a_busy_ignore: assert property (encrypt_busy && !encrypt_done |=> encrypt_busy)
    else $error("encryption aborted");

  a_key_prio: assert property (
    s_key_req ##0 plain_valid |=> key_load_busy && !encrypt_busy)
    else $error("plaintext won over key");

  a_valid_pulse: assert property (cipher_valid |=> !cipher_valid)
    else $error("valid longer than one cycle");

  // A reset clears the ciphertext without a strobe, so that edge is exempt
  a_cipher_hold: assert property (
    $past(reset_n) && !$stable(cipher_block) |-> cipher_valid)
    else $error("ciphertext changed without valid");

  a_key_retain: assert property (!key_start |=> $stable(rk_q[0]))
    else $error("key changed without load");

  a_key_capture: assert property (
    s_key_req |=> {rk_q[0], rk_q[1]} == $past(key_word))
    else $error("key word not captured");

  a_key_ignore: assert property (key_load_busy && !key_load_done |=> key_load_busy)
    else $error("key setting aborted");

  a_key_blocks_enc: assert property (key_load_busy |=> !encrypt_busy)
    else $error("plaintext taken during key setting");

  a_enc_blocks_key: assert property (encrypt_busy |=> !key_load_busy)
    else $error("key taken during encryption");

  a_enc_start: assert property (s_enc_req |=> encrypt_busy && !encrypt_done)
    else $error("encryption busy not raised");

  a_enc_finish: assert property (encrypt_done |-> s_enc_finish)
    else $error("result not after last busy cycle");

  a_key_finish: assert property (key_load_done |-> s_key_finish)
    else $error("key setting did not end after done");

  a_enc_done_once: assert property (encrypt_done |=> !encrypt_done)
    else $error("encryption done longer than one cycle");

  a_key_done_once: assert property (key_load_done |=> !key_load_done)
    else $error("key done longer than one cycle");

  a_enc_done_busy: assert property (!encrypt_busy |-> !encrypt_done)
    else $error("encryption done outside busy");

  a_key_done_busy: assert property (!key_load_busy |-> !key_load_done)
    else $error("key done outside busy");

  a_valid_idle: assert property (cipher_valid |-> !encrypt_busy && !key_load_busy)
    else $error("result while busy");

endmodule : aesenc_top

/* tb/aesenc_user.sv */
`timescale 1ns/1ns
module aesenc_user (
  // Clock
  input  wire logic                      sys_clk,
  // Requests
  output aesenc_pkg::aesenc_key_t        key_word,
  output logic                           key_load_valid,
  output aesenc_pkg::aesenc_block_t      plain_block,
  output logic                           plain_valid,
  // Status
  input  wire logic                      key_load_busy,
  input  wire logic                      key_load_done,
  input  wire logic                      encrypt_busy,
  input  wire logic                      encrypt_done
);
  integer seed = 32'hB77A;

  initial begin
    key_word       = '0;
    key_load_valid = 1'b0;
    plain_block    = '0;
    plain_valid    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Called at an edge; stray pokes land mid-operation, in cycle 6
  task automatic req(input logic kv, input aesenc_pkg::aesenc_key_t k,
                     input logic pv, input aesenc_pkg::aesenc_block_t p,
                     input logic pk, input logic pp, output int lat, output int bcnt);
    lat  = 0;
    bcnt = 0;
    key_load_valid <= kv;
    key_word       <= k;
    plain_valid    <= pv;
    plain_block    <= p;
    @(posedge sys_clk);
    key_load_valid <= 1'b0;
    plain_valid    <= 1'b0;
    // Hold time over: scramble so nothing leans on stale data
    key_word       <= {8{$random(seed)}};
    plain_block    <= {4{$random(seed)}};
    while (lat < 40) begin
      @(posedge sys_clk);
      lat++;
      // Only touch the strobes around the poke, so a following call owns the done edge
      if (lat == 5 || lat == 6) begin
        key_load_valid <= (lat == 5) ? pk : 1'b0;
        plain_valid    <= (lat == 5) ? pp : 1'b0;
      end
      if (key_load_busy || encrypt_busy) bcnt++;
      if (key_load_done || encrypt_done) break;
    end
  endtask : req

  task automatic idle();
    repeat ($unsigned($random(seed)) % 4) @(posedge sys_clk);
  endtask : idle
endmodule : aesenc_user

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  localparam aesenc_pkg::aesenc_key_t KEY_A =
    256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
  localparam aesenc_pkg::aesenc_key_t KEY_B =
    256'h603DEB1015CA71BE2B73AEF0857D77811F352C073B6108D72D9810A30914DFF4;
  localparam aesenc_pkg::aesenc_block_t PT_A = 128'h00112233445566778899AABBCCDDEEFF;
  localparam aesenc_pkg::aesenc_block_t CT_A = 128'h8EA2B7CA516745BFEAFC49904B496089;
  localparam aesenc_pkg::aesenc_block_t PT_B [4] = '{
    128'h6BC1BEE22E409F96E93D7E117393172A, 128'hAE2D8A571E03AC9C9EB76FAC45AF8E51,
    128'h30C81C46A35CE411E5FBC1191A0A52EF, 128'hF69F2445DF4F9B17AD2B417BE66C3710};
  localparam aesenc_pkg::aesenc_block_t CT_B [4] = '{
    128'hF3EED1BDB5D2A03C064B5A7E3DB181F8, 128'h591CCB10D410ED26DC5BA74A31362870,
    128'hB6ED21B99CA6F4F9F153E7B1BEAFED1D, 128'h23304B7A39F9F3FF067D8D8F9E24ECC7};

  logic                      sys_clk;
  logic                      reset_n;
  logic                      key_load_valid;
  aesenc_pkg::aesenc_key_t   key_word;
  logic                      key_load_busy;
  logic                      key_load_done;
  logic                      plain_valid;
  aesenc_pkg::aesenc_block_t plain_block;
  logic                      encrypt_busy;
  logic                      encrypt_done;
  logic                      cipher_valid;
  aesenc_pkg::aesenc_block_t cipher_block;
  aesenc_pkg::aesenc_block_t exp_q [$];
  aesenc_pkg::aesenc_block_t last_ct;
  logic                      prev_done;
  int                        mismatches;
  int                        total_checks;
  int                        cycles;
  int                        lat;
  int                        bcnt;
  int                        lat_x;
  int                        bcnt_x;

  aesenc_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .key_load_valid(key_load_valid),
    .key_word(key_word), .key_load_busy(key_load_busy), .key_load_done(key_load_done),
    .plain_valid(plain_valid), .plain_block(plain_block), .encrypt_busy(encrypt_busy),
    .encrypt_done(encrypt_done), .cipher_valid(cipher_valid), .cipher_block(cipher_block));

  aesenc_user u_user (.sys_clk(sys_clk), .key_word(key_word),
    .key_load_valid(key_load_valid), .plain_block(plain_block), .plain_valid(plain_valid),
    .key_load_busy(key_load_busy), .key_load_done(key_load_done),
    .encrypt_busy(encrypt_busy), .encrypt_done(encrypt_done));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] expv);
    total_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs read at the edge show the cycle just ended
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
    if (reset_n) begin
      check(128'(cipher_valid), 128'(prev_done));
      if (cipher_valid === 1'b1) begin
        // Empty queue means a request slipped through that should not have
        check(128'(exp_q.size() != 0), 128'h1);
        if (exp_q.size() != 0) check(cipher_block, exp_q.pop_front());
        last_ct = cipher_block;
      end else begin
        check(cipher_block, last_ct);
      end
    end else begin
      last_ct = '0;
    end
    prev_done = encrypt_done;
  end

  initial begin
    reset_n      = 1'b0;
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    prev_done    = 1'b0;
    last_ct      = '0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    check(128'({key_load_busy, key_load_done, encrypt_busy, cipher_valid}), 128'h0);
    @(posedge sys_clk);
    u_user.req(1'b1, KEY_A, 1'b0, '0, 1'b0, 1'b1, lat, bcnt);
    check(128'(lat), 128'hE);
    check(128'(bcnt), 128'hE);
    exp_q.push_back(CT_A);
    u_user.req(1'b0, '0, 1'b1, PT_A, 1'b1, 1'b0, lat, bcnt);
    check(128'(lat), 128'hE);
    check(128'(bcnt), 128'hE);
    u_user.idle();
    exp_q.push_back(CT_A);
    u_user.req(1'b0, '0, 1'b1, PT_A, 1'b0, 1'b0, lat, bcnt);
    u_user.idle();
    // Both requests together: only the key may be taken
    u_user.req(1'b1, KEY_B, 1'b1, PT_A, 1'b0, 1'b0, lat, bcnt);
    check(128'(lat), 128'hE);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(CT_B[i]);
      u_user.req(1'b0, '0, 1'b1, PT_B[i], 1'b0, 1'b0, lat, bcnt);
      check(128'(lat), 128'hE);
    end
    // Reset in mid encryption drops the block
    fork
      u_user.req(1'b0, '0, 1'b1, PT_B[0], 1'b0, 1'b0, lat_x, bcnt_x);
    join_none
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(128'({key_load_busy, key_load_done, encrypt_busy,
                encrypt_done, cipher_valid}), 128'h0);
    check(cipher_block, '0);
    reset_n <= 1'b1;
    wait fork;
    // Cut block: no done within the limit, busy only until reset took hold
    check(128'(lat_x), 128'h28);
    check(128'(bcnt_x), 128'h5);
    u_user.req(1'b1, KEY_A, 1'b0, '0, 1'b0, 1'b0, lat, bcnt);
    exp_q.push_back(CT_A);
    u_user.req(1'b0, '0, 1'b1, PT_A, 1'b0, 1'b0, lat, bcnt);
    repeat (3) @(posedge sys_clk);
    check(128'(exp_q.size()), 128'h0);
    summarize();
  end
endmodule : tb
